// >>> design/count_clock_select.sv
module count_clock_select (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire timer16_pkg::count_source_t sel,
    input  wire logic [3:0]                 prescale_taps,
    input  wire logic                       pin,
    output logic                            tick
);

    logic pin_q;

    // Pin is sampled whatever its direction
    always_ff @(posedge clk)
    begin
        if (rst)
            pin_q <= 1'b0;
        else
            pin_q <= pin;
    end

    always_comb
    begin
        case (sel)
            timer16_pkg::SRC_STOP:     tick = 1'b0;
            timer16_pkg::SRC_DIV1:     tick = 1'b1;
            timer16_pkg::SRC_DIV8:     tick = prescale_taps[0];
            timer16_pkg::SRC_DIV64:    tick = prescale_taps[1];
            timer16_pkg::SRC_DIV256:   tick = prescale_taps[2];
            timer16_pkg::SRC_DIV1024:  tick = prescale_taps[3];
            timer16_pkg::SRC_PIN_FALL: tick = pin_q & ~pin;
            timer16_pkg::SRC_PIN_RISE: tick = ~pin_q & pin;
            default:                   tick = 1'b0;
        endcase
    end

endmodule

// >>> design/timer16_clock_force_counter.sv
// Overview of operation
// - Source zero stops; codes 1-5 divide clock
// - Codes six, seven count pin falls, rises
// - Pin edges count even when pin drives
// - Force strobes ignored in PWM modes
// - Force applies compare match to output pin
// - Force is strobe; current output mode decides
// - Force sets no flag, never clears counter
// - Force bits always read back zero
// - Counter bytes move atomically through holding byte
// - One holding byte shared by all timers
// - Counter write blocks match next timer tick
// - Non-PWM modes are codes 0, 4, 12
module timer16_clock_force_counter (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire timer16_pkg::bus_req_t                  bus_req,
    input  wire timer16_pkg::timer_cfg_t [3:0]          cfg,
    input  wire logic [3:0][2:0][15:0]                  compare_value,
    input  wire logic [3:0]                             external_count_pin,
    output logic [7:0]                                  read_data,
    output logic [3:0][15:0]                            count_value,
    output logic [3:0][2:0]                             compare_out_pin,
    output logic [3:0][2:0]                             compare_match
);

    localparam logic [8:0] FORCE_ADDR [4] = '{
        timer16_pkg::FORCE_COMPARE_CTRL_T1_ADDR, timer16_pkg::FORCE_COMPARE_CTRL_T3_ADDR,
        timer16_pkg::FORCE_COMPARE_CTRL_T4_ADDR, timer16_pkg::FORCE_COMPARE_CTRL_T5_ADDR};
    localparam logic [8:0] LOW_ADDR [4] = '{
        timer16_pkg::COUNTER_LOW_T1_ADDR, timer16_pkg::COUNTER_LOW_T3_ADDR,
        timer16_pkg::COUNTER_LOW_T4_ADDR, timer16_pkg::COUNTER_LOW_T5_ADDR};
    localparam logic [8:0] HIGH_ADDR [4] = '{
        timer16_pkg::COUNTER_HIGH_T1_ADDR, timer16_pkg::COUNTER_HIGH_T3_ADDR,
        timer16_pkg::COUNTER_HIGH_T4_ADDR, timer16_pkg::COUNTER_HIGH_T5_ADDR};

    logic [9:0]              prescale_q;
    logic [3:0]              taps;
    logic [7:0]              temp_q;
    logic [7:0]              rdata_q;
    logic [3:0]              hit_force;
    logic [3:0]              hit_low;
    logic [3:0]              hit_high;
    logic [3:0]              cnt_wr_q;
    logic [3:0][15:0]        cnt_wdata_q;
    logic [3:0][2:0]         force_q;
    logic [3:0]              block_q;
    logic [3:0][15:0]        count_q;
    logic [3:0][2:0]         pin_q;
    logic [3:0][2:0]         flag_q;
    logic [3:0]              tick_w;
    logic [3:0]              pwm_w;
    logic [3:0][2:0]         match_w;

    function automatic logic next_pin(input logic cur, input logic [1:0] com);
        case (com)
            timer16_pkg::COM_TOGGLE: next_pin = ~cur;
            timer16_pkg::COM_CLEAR:  next_pin = 1'b0;
            timer16_pkg::COM_SET:    next_pin = 1'b1;
            default:                 next_pin = cur;
        endcase
    endfunction

    // Shared prescaler feeding all timers
    always_ff @(posedge clk)
    begin
        if (rst)
            prescale_q <= timer16_pkg::PRESCALE_RESET;
        else
            prescale_q <= prescale_q + 10'h001;
    end

    always_comb
    begin
        taps[0] = (prescale_q & timer16_pkg::DIV8_MASK) == timer16_pkg::DIV8_MASK;
        taps[1] = (prescale_q & timer16_pkg::DIV64_MASK) == timer16_pkg::DIV64_MASK;
        taps[2] = (prescale_q & timer16_pkg::DIV256_MASK) == timer16_pkg::DIV256_MASK;
        taps[3] = prescale_q == timer16_pkg::DIV1024_MASK;
    end

    // Address decode
    always_comb
    begin
        for (int t = 0; t < timer16_pkg::NUM_TIMERS; t++)
        begin
            hit_force[t] = bus_req.addr == FORCE_ADDR[t];
            hit_low[t]   = bus_req.addr == LOW_ADDR[t];
            hit_high[t]  = bus_req.addr == HIGH_ADDR[t];
        end
    end

    // Single holding byte for every 16-bit access
    always_ff @(posedge clk)
    begin
        if (rst)
            temp_q <= timer16_pkg::TEMP_RESET;
        else if (bus_req.wr)
        begin
            for (int t = 0; t < timer16_pkg::NUM_TIMERS; t++)
                if (hit_high[t])
                    temp_q <= bus_req.wdata;
        end
        else if (bus_req.rd)
        begin
            for (int t = 0; t < timer16_pkg::NUM_TIMERS; t++)
                if (hit_low[t])
                    temp_q <= count_q[t][15:8];
        end
    end

    // Read data, one cycle after the request
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_q <= timer16_pkg::READ_RESET;
        else if (bus_req.rd)
        begin
            rdata_q <= timer16_pkg::READ_RESET;
            for (int t = 0; t < timer16_pkg::NUM_TIMERS; t++)
            begin
                if (hit_low[t])
                    rdata_q <= count_q[t][7:0];
                if (hit_high[t])
                    rdata_q <= temp_q;
            end
        end
    end

    // Low-byte write commits the full word, force bits are strobes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_wr_q    <= '0;
            cnt_wdata_q <= '0;
            force_q     <= '0;
        end
        else
        begin
            for (int t = 0; t < timer16_pkg::NUM_TIMERS; t++)
            begin
                cnt_wr_q[t] <= bus_req.wr && hit_low[t];
                if (bus_req.wr && hit_low[t])
                    cnt_wdata_q[t] <= {temp_q, bus_req.wdata};
                force_q[t] <= (bus_req.wr && hit_force[t]) ?
                    {bus_req.wdata[timer16_pkg::FORCE_MATCH_C_BIT],
                     bus_req.wdata[timer16_pkg::FORCE_MATCH_B_BIT],
                     bus_req.wdata[timer16_pkg::FORCE_MATCH_A_BIT]} : 3'h0;
            end
        end
    end

    for (genvar t = 0; t < timer16_pkg::NUM_TIMERS; t++)
    begin : g_timer
        count_clock_select u_sel (
            .clk           (clk),
            .rst           (rst),
            .sel           (cfg[t].count_source_select),
            .prescale_taps (taps),
            .pin           (external_count_pin[t]),
            .tick          (tick_w[t])
        );

        assign pwm_w[t] = !(cfg[t].waveform_mode == timer16_pkg::MODE_NORMAL ||
                            cfg[t].waveform_mode == timer16_pkg::MODE_CLEAR_A ||
                            cfg[t].waveform_mode == timer16_pkg::MODE_CLEAR_CAPTURE);

        for (genvar c = 0; c < timer16_pkg::NUM_CH; c++)
        begin : g_ch
            assign match_w[t][c] = tick_w[t] && !block_q[t] && !cnt_wr_q[t] &&
                                   count_q[t] == compare_value[t][c];
        end

        // Match blocking after a counter write
        always_ff @(posedge clk)
        begin
            if (rst)
                block_q[t] <= 1'b0;
            else if (cnt_wr_q[t])
                block_q[t] <= 1'b1;
            else if (tick_w[t])
                block_q[t] <= 1'b0;
        end

        always_ff @(posedge clk)
        begin
            if (rst)
                count_q[t] <= timer16_pkg::COUNT_RESET;
            else if (cnt_wr_q[t])
                count_q[t] <= cnt_wdata_q[t];
            else if (tick_w[t])
            begin
                if (cfg[t].waveform_mode == timer16_pkg::MODE_CLEAR_A && match_w[t][0])
                    count_q[t] <= timer16_pkg::COUNT_RESET;
                else
                    count_q[t] <= count_q[t] + 16'h0001;
            end
        end

        // Flags follow real matches only
        always_ff @(posedge clk)
        begin
            if (rst)
                flag_q[t] <= '0;
            else
                flag_q[t] <= match_w[t];
        end

        always_ff @(posedge clk)
        begin
            if (rst)
                pin_q[t] <= '0;
            else
            begin
                for (int c = 0; c < timer16_pkg::NUM_CH; c++)
                    if (!pwm_w[t] && (force_q[t][c] || match_w[t][c]))
                        pin_q[t][c] <= next_pin(pin_q[t][c],
                                                cfg[t].compare_output_mode[c]);
            end
        end
    end

    assign read_data       = rdata_q;
    assign count_value     = count_q;
    assign compare_out_pin = pin_q;
    assign compare_match   = flag_q;

    // Checks on the first timer
    property p_stop_holds;
        @(posedge clk) disable iff (rst)
        (cfg[0].count_source_select == timer16_pkg::SRC_STOP && !cnt_wr_q[0])
            |=> $stable(count_q[0]);
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("counter moved while stopped");

    property p_div8_spacing;
        @(posedge clk) disable iff (rst)
        (tick_w[0] && cfg[0].count_source_select == timer16_pkg::SRC_DIV8)
            |=> (!tick_w[0] || cfg[0].count_source_select != timer16_pkg::SRC_DIV8)[*7];
    endproperty
    a_div8_spacing: assert property (p_div8_spacing)
        else $error("divide by 8 tick too early");

    property p_pin_rise;
        @(posedge clk) disable iff (rst)
        (cfg[0].count_source_select == timer16_pkg::SRC_PIN_RISE &&
         $rose(external_count_pin[0]) && !cnt_wr_q[0] &&
         cfg[0].waveform_mode == timer16_pkg::MODE_NORMAL)
            |=> count_q[0] == $past(count_q[0]) + 16'h0001;
    endproperty
    a_pin_rise: assert property (p_pin_rise)
        else $error("rising pin edge not counted");

    property p_force_pwm;
        @(posedge clk) disable iff (rst)
        (force_q[0] != 3'h0 && pwm_w[0]) |=> $stable(pin_q[0]);
    endproperty
    a_force_pwm: assert property (p_force_pwm)
        else $error("force acted in PWM mode");

    sequence s_force_set_a;
        force_q[0][0] && !pwm_w[0] &&
        cfg[0].compare_output_mode[0] == timer16_pkg::COM_SET;
    endsequence
    property p_force_set;
        @(posedge clk) disable iff (rst)
        s_force_set_a |=> pin_q[0][0];
    endproperty
    a_force_set: assert property (p_force_set)
        else $error("forced set did not drive pin high");

    property p_force_no_side;
        @(posedge clk) disable iff (rst)
        (force_q[0][0] && !tick_w[0] && !cnt_wr_q[0])
            |=> !flag_q[0][0] && $stable(count_q[0]);
    endproperty
    a_force_no_side: assert property (p_force_no_side)
        else $error("force raised flag or moved counter");

    property p_force_reads_zero;
        @(posedge clk) disable iff (rst)
        (bus_req.rd && !bus_req.wr && hit_force[0]) |=> rdata_q == 8'h00;
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero)
        else $error("force register read nonzero");

    sequence s_low_write;
        bus_req.wr && hit_low[0];
    endsequence
    property p_atomic_write;
        @(posedge clk) disable iff (rst)
        s_low_write |=> (cnt_wdata_q[0] == {$past(temp_q), $past(bus_req.wdata)})
            ##1 count_q[0] == $past(cnt_wdata_q[0]);
    endproperty
    a_atomic_write: assert property (p_atomic_write)
        else $error("16-bit write not committed whole");

    property p_shared_temp;
        @(posedge clk) disable iff (rst)
        (bus_req.wr && hit_high[0]) ##1 (!(bus_req.wr || bus_req.rd))[*2]
            ##1 (bus_req.rd && !bus_req.wr && hit_high[1])
            |=> rdata_q == $past(bus_req.wdata, 4);
    endproperty
    a_shared_temp: assert property (p_shared_temp)
        else $error("holding byte not shared");

    property p_block_match;
        @(posedge clk) disable iff (rst)
        cnt_wr_q[0] ##1 (!tick_w[0] && !cnt_wr_q[0])[*2] ##1 (tick_w[0] && !cnt_wr_q[0])
            |=> flag_q[0] == 3'h0;
    endproperty
    a_block_match: assert property (p_block_match)
        else $error("match not blocked after counter write");

endmodule

// >>> design/timer16_pkg.sv
package timer16_pkg;

    localparam int NUM_TIMERS = 4;
    localparam int NUM_CH     = 3;

    // Byte addresses of the force and counter registers
    localparam logic [8:0] FORCE_COMPARE_CTRL_T1_ADDR = 9'h082;
    localparam logic [8:0] COUNTER_LOW_T1_ADDR        = 9'h084;
    localparam logic [8:0] COUNTER_HIGH_T1_ADDR       = 9'h085;
    localparam logic [8:0] FORCE_COMPARE_CTRL_T3_ADDR = 9'h092;
    localparam logic [8:0] COUNTER_LOW_T3_ADDR        = 9'h094;
    localparam logic [8:0] COUNTER_HIGH_T3_ADDR       = 9'h095;
    localparam logic [8:0] FORCE_COMPARE_CTRL_T4_ADDR = 9'h0A2;
    localparam logic [8:0] COUNTER_LOW_T4_ADDR        = 9'h0A4;
    localparam logic [8:0] COUNTER_HIGH_T4_ADDR       = 9'h0A5;
    localparam logic [8:0] FORCE_COMPARE_CTRL_T5_ADDR = 9'h122;
    localparam logic [8:0] COUNTER_LOW_T5_ADDR        = 9'h124;
    localparam logic [8:0] COUNTER_HIGH_T5_ADDR       = 9'h125;

    // Force strobe bit positions
    localparam int FORCE_MATCH_A_BIT = 7;
    localparam int FORCE_MATCH_B_BIT = 6;
    localparam int FORCE_MATCH_C_BIT = 5;

    // Reset values
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [7:0]  TEMP_RESET     = 8'h00;
    localparam logic [7:0]  READ_RESET     = 8'h00;
    localparam logic [9:0]  PRESCALE_RESET = 10'h000;

    // Prescaler tap masks
    localparam logic [9:0] DIV8_MASK    = 10'h007;
    localparam logic [9:0] DIV64_MASK   = 10'h03F;
    localparam logic [9:0] DIV256_MASK  = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;

    // Waveform modes without PWM
    localparam logic [3:0] MODE_NORMAL        = 4'h0;
    localparam logic [3:0] MODE_CLEAR_A       = 4'h4;
    localparam logic [3:0] MODE_CLEAR_CAPTURE = 4'hC;

    // Compare output actions
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    typedef enum logic [2:0] {
        SRC_STOP     = 3'h0,
        SRC_DIV1     = 3'h1,
        SRC_DIV8     = 3'h2,
        SRC_DIV64    = 3'h3,
        SRC_DIV256   = 3'h4,
        SRC_DIV1024  = 3'h5,
        SRC_PIN_FALL = 3'h6,
        SRC_PIN_RISE = 3'h7
    } count_source_t;

    typedef struct packed {
        logic [3:0]      waveform_mode;
        count_source_t   count_source_select;
        logic [2:0][1:0] compare_output_mode;
    } timer_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

endpackage

// >>> testbench/count_pin_source.sv
module count_pin_source (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] run,
    input  wire logic [3:0] half_period,
    output logic [3:0]      pin = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt [4];

    // Each lane toggles every half_period cycles while run, else holds its level
    always @(negedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (rst)
            begin
                pin[i] <= 1'b0;
                cnt[i] <= 4'h0;
            end
            else if (run[i] && cnt[i] + 4'h1 >= half_period)
            begin
                pin[i] <= ~pin[i];
                cnt[i] <= 4'h0;
            end
            else if (run[i])
            begin
                cnt[i] <= cnt[i] + 4'h1;
            end
        end
    end
endmodule

// >>> testbench/test_timer16_clock_force_counter.sv
`define CHECK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("unexpected at %0t: got %h want %h", $time, got, exp); \
        end \
    end

module test_timer16_clock_force_counter;
    timeunit 1ns;
    timeprecision 1ps;

    logic                          clk = 1'b0;
    logic                          rst = 1'b1;
    timer16_pkg::bus_req_t         bus_req = '0;
    timer16_pkg::timer_cfg_t [3:0] cfg = '0;
    logic [3:0][2:0][15:0]         compare_value = '0;
    logic [3:0]                    external_count_pin;
    logic [3:0]                    run = 4'h0;
    logic [3:0]                    half = 4'h1;
    logic [7:0]                    read_data;
    logic [3:0][15:0]              count_value;
    logic [3:0][2:0]               compare_out_pin;
    logic [3:0][2:0]               compare_match;
    logic [3:0][2:0]               exp_pin = '0;
    logic [3:0]                    pin_prev = 4'h0;
    logic [15:0]                   exp_cnt [4] = '{default: 16'h0000};
    logic [31:0]                   seed = 32'h19;
    int                            checks = 0;
    int                            miscompares = 0;
    int                            match_a0 = 0;
    int                            match_any = 0;
    int                            rises [4] = '{default: 0};
    int                            falls [4] = '{default: 0};
    logic [8:0] lo [4] = '{timer16_pkg::COUNTER_LOW_T1_ADDR, timer16_pkg::COUNTER_LOW_T3_ADDR,
                           timer16_pkg::COUNTER_LOW_T4_ADDR, timer16_pkg::COUNTER_LOW_T5_ADDR};
    logic [8:0] fc [4] = '{timer16_pkg::FORCE_COMPARE_CTRL_T1_ADDR,
                           timer16_pkg::FORCE_COMPARE_CTRL_T3_ADDR,
                           timer16_pkg::FORCE_COMPARE_CTRL_T4_ADDR,
                           timer16_pkg::FORCE_COMPARE_CTRL_T5_ADDR};

    always #5 clk = ~clk;

    timer16_clock_force_counter timer16_clock_force_counter_inst (
        .clk                (clk),
        .rst                (rst),
        .bus_req            (bus_req),
        .cfg                (cfg),
        .compare_value      (compare_value),
        .external_count_pin (external_count_pin),
        .read_data          (read_data),
        .count_value        (count_value),
        .compare_out_pin    (compare_out_pin),
        .compare_match      (compare_match)
    );

    count_pin_source count_pin_source_inst (
        .clk         (clk),
        .rst         (rst),
        .run         (run),
        .half_period (half),
        .pin         (external_count_pin)
    );

    // Edge and match monitors
    always @(posedge clk)
    begin
        pin_prev <= external_count_pin;
        match_a0 += int'(compare_match[0][0] === 1'b1);
        match_any += int'(|compare_match !== 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            rises[i] += int'(external_count_pin[i] & ~pin_prev[i]);
            falls[i] += int'(~external_count_pin[i] & pin_prev[i]);
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic force_result(logic [3:0] m, logic [1:0] com, logic p);
        if (m != timer16_pkg::MODE_NORMAL && m != timer16_pkg::MODE_CLEAR_A
            && m != timer16_pkg::MODE_CLEAR_CAPTURE)
            return p;
        case (com)
            timer16_pkg::COM_TOGGLE: return ~p;
            timer16_pkg::COM_CLEAR:  return 1'b0;
            timer16_pkg::COM_SET:    return 1'b1;
            default:                 return p;
        endcase
    endfunction

    task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge clk);
        bus_req = '0;
        @(negedge clk);
    endtask

    // Counter is written only while stopped
    task automatic wr16(input int t, input logic [15:0] v);
        bus(1'b1, lo[t] + 9'h001, v[15:8]);
        bus(1'b1, lo[t], v[7:0]);
        repeat (2) @(negedge clk);
        exp_cnt[t] = v;
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run is near 12800 cycles; limit is near eight times that
    initial
    begin
        #1000000;
        miscompares++;
        finish_test();
    end

    initial
    begin
        static logic [3:0] modes [8] = '{4'h0, 4'h4, 4'hC, 4'h1, 4'h5, 4'hF, 4'h4, 4'h0};
        static int shifts [6] = '{0, 0, 3, 6, 8, 10};
        logic [15:0] c;
        int t;
        int m0;
        for (int i = 0; i < 12; i++)
            compare_value[i / 3][i % 3] = 16'(rnd());
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (t = 0; t < 4; t++)
        begin
            bus(1'b0, lo[t], 8'h00);
            `CHECK(read_data, 8'h00)
            bus(1'b0, fc[t], 8'h00);
            `CHECK(read_data, 8'h00)
            wr16(t, 16'(rnd()));
            `CHECK(count_value[t], exp_cnt[t])
            bus(1'b0, lo[t], 8'h00);
            `CHECK(read_data, exp_cnt[t][7:0])
            bus(1'b0, lo[t] + 9'h001, 8'h00);
            `CHECK(read_data, exp_cnt[t][15:8])
        end
        bus(1'b0, 9'h083, 8'h00);
        `CHECK(read_data, 8'h00)
        bus(1'b1, lo[0] + 9'h001, 8'hA5);
        bus(1'b1, lo[1] + 9'h001, 8'h3C);
        bus(1'b1, lo[0], 8'h5A);
        repeat (2) @(negedge clk);
        exp_cnt[0] = 16'h3C5A;
        `CHECK(count_value[0], exp_cnt[0])
        bus(1'b0, lo[2], 8'h00);
        bus(1'b0, lo[0] + 9'h001, 8'h00);
        `CHECK(read_data, exp_cnt[2][15:8])
        bus(1'b1, lo[0] + 9'h001, 8'hC3);
        bus(1'b0, lo[1] + 9'h001, 8'h00);
        `CHECK(read_data, 8'hC3)
        for (int k = 0; k < 8; k++)
        begin
            t = k % 4;
            cfg[t].waveform_mode = modes[k];
            compare_value[t][0] = exp_cnt[t];
            for (int ch = 0; ch < 3; ch++)
            begin
                cfg[t].compare_output_mode[ch] = (k == 0) ? 2'(3 - ch) : 2'(rnd());
                exp_pin[t][ch] = force_result(modes[k], cfg[t].compare_output_mode[ch],
                                              exp_pin[t][ch]);
            end
            bus(1'b1, fc[t], 8'hE0);
            @(negedge clk);
            `CHECK(compare_out_pin[t], exp_pin[t])
            `CHECK(count_value[t], exp_cnt[t])
        end
        `CHECK(match_any, 0)
        for (int code = 0; code < 6; code++)
        begin
            t = code % 4;
            cfg[t].waveform_mode = timer16_pkg::MODE_NORMAL;
            wr16(t, 16'h0000);
            cfg[t].count_source_select = timer16_pkg::count_source_t'(code);
            repeat (2048) @(negedge clk);
            cfg[t].count_source_select = timer16_pkg::SRC_STOP;
            repeat (4) @(negedge clk);
            `CHECK(count_value[t], (code == 0) ? 16'h0000 : 16'(2048 >> shifts[code]))
        end
        for (t = 0; t < 4; t++)
        begin
            half = 4'(rnd() % 5 + 1);
            cfg[t].waveform_mode = timer16_pkg::MODE_NORMAL;
            wr16(t, 16'h0000);
            cfg[t].count_source_select = t[0] ? timer16_pkg::SRC_PIN_FALL
                                              : timer16_pkg::SRC_PIN_RISE;
            m0 = t[0] ? falls[t] : rises[t];
            @(negedge clk);
            run[t] = 1'b1;
            repeat (40 + rnd() % 40) @(negedge clk);
            run[t] = 1'b0;
            repeat (4) @(negedge clk);
            cfg[t].count_source_select = timer16_pkg::SRC_STOP;
            `CHECK(count_value[t], 16'((t[0] ? falls[t] : rises[t]) - m0))
        end
        c = compare_value[0][0];
        compare_value[0][1] = c ^ 16'h8000;
        compare_value[0][2] = c ^ 16'h8000;
        for (int k = 0; k < 2; k++)
        begin
            wr16(0, c - 16'(2 * k));
            m0 = match_a0;
            cfg[0].count_source_select = timer16_pkg::SRC_DIV1;
            repeat (6) @(negedge clk);
            cfg[0].count_source_select = timer16_pkg::SRC_STOP;
            repeat (3) @(negedge clk);
            `CHECK(match_a0 - m0, k)
        end
        finish_test();
    end
endmodule
